// ==== flash_key_pkg.sv ====
package flash_key_pkg;
  localparam logic [7:0] FLASH_TIMING_SCALE_ADDR = 8'hB6;
  localparam logic [7:0] FLASH_UNLOCK_KEY_ADDR   = 8'hB7;
  localparam logic [7:0] FLASH_TIMING_SCALE_RST  = 8'h80;
  localparam int         ONESHOT_BIT             = 7;
  localparam int         READ_TIME_BIT           = 4;
  localparam logic [7:0] KEY_FIRST               = 8'hA5;
  localparam logic [7:0] KEY_SECOND              = 8'hF1;
  localparam logic [1:0] LOCK_LOCKED             = 2'h0;
  localparam logic [1:0] LOCK_FIRST_SEEN         = 2'h1;
  localparam logic [1:0] LOCK_OPEN               = 2'h2;
  localparam logic [1:0] LOCK_DEAD               = 2'h3;
  typedef enum logic [1:0] {
    KEY_LOCKED,
    KEY_HALF,
    KEY_OPEN,
    KEY_DEAD
  } key_state_t;
endpackage

// ==== flash_read_strobe.sv ====
`timescale 1ns/100ps
module flash_read_strobe
  import flash_key_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic read_req_i,
  input  wire logic oneshot_en_i,
  output logic      sense_en_o
);
  // One-shot mode pulses the sense amps for the first cycle only; off keeps them on the whole read
  logic read_d_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      read_d_r <= 1'b0;
    end else begin
      read_d_r <= read_req_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sense_en_o <= 1'b0;
    end else if (oneshot_en_i) begin
      sense_en_o <= read_req_i & ~read_d_r;
    end else begin
      sense_en_o <= read_req_i;
    end
  end
endmodule

// ==== flash_key_ctrl.sv ====
`timescale 1ns/100ps
module flash_key_ctrl
  import flash_key_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic       program_write_enable_i,
  input  wire logic       xmove_wr_i,
  input  wire logic       flash_read_i,
  output logic [7:0]      sfr_rdata_o,
  output logic            flash_wr_go_o,
  output logic            xram_wr_go_o,
  output logic            flash_locked_o,
  output logic            read_time_select_o,
  output logic            sense_en_o
);
  key_state_t key_r;
  key_state_t key_nxt;
  logic       oneshot_r;
  logic       rtime_r;
  logic       key_wr;
  logic       scale_wr;
  logic       flash_op;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  assign key_wr   = sfr_wr_i & hit(sfr_addr_i, FLASH_UNLOCK_KEY_ADDR);
  assign scale_wr = sfr_wr_i & hit(sfr_addr_i, FLASH_TIMING_SCALE_ADDR);
  assign flash_op = xmove_wr_i & program_write_enable_i;

  always_comb begin
    key_nxt = key_r;
    case (key_r)
      KEY_LOCKED: begin
        if (flash_op) begin
          key_nxt = KEY_DEAD;
        end else if (key_wr) begin
          key_nxt = (sfr_wdata_i == KEY_FIRST) ? KEY_HALF : KEY_DEAD;
        end
      end
      KEY_HALF: begin
        if (flash_op) begin
          key_nxt = KEY_DEAD;
        end else if (key_wr) begin
          key_nxt = (sfr_wdata_i == KEY_SECOND) ? KEY_OPEN : KEY_DEAD;
        end
      end
      KEY_OPEN: begin
        // Another key write while open is a misordered key and kills access
        if (flash_op) begin
          key_nxt = KEY_LOCKED;
        end else if (key_wr) begin
          key_nxt = KEY_DEAD;
        end
      end
      KEY_DEAD: key_nxt = KEY_DEAD;
      default:  key_nxt = KEY_DEAD;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      key_r <= KEY_LOCKED;
    end else begin
      key_r <= key_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oneshot_r <= FLASH_TIMING_SCALE_RST[ONESHOT_BIT];
      rtime_r   <= FLASH_TIMING_SCALE_RST[READ_TIME_BIT];
    end else if (scale_wr) begin
      oneshot_r <= sfr_wdata_i[ONESHOT_BIT];
      rtime_r   <= sfr_wdata_i[READ_TIME_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= 8'h00;
      if (hit(sfr_addr_i, FLASH_TIMING_SCALE_ADDR)) begin
        sfr_rdata_o[ONESHOT_BIT]   <= oneshot_r;
        sfr_rdata_o[READ_TIME_BIT] <= rtime_r;
      end else if (hit(sfr_addr_i, FLASH_UNLOCK_KEY_ADDR)) begin
        case (key_r)
          KEY_LOCKED: sfr_rdata_o[1:0] <= LOCK_LOCKED;
          KEY_HALF:   sfr_rdata_o[1:0] <= LOCK_FIRST_SEEN;
          KEY_OPEN:   sfr_rdata_o[1:0] <= LOCK_OPEN;
          default:    sfr_rdata_o[1:0] <= LOCK_DEAD;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_wr_go_o      <= 1'b0;
      xram_wr_go_o       <= 1'b0;
      flash_locked_o     <= 1'b1;
      read_time_select_o <= FLASH_TIMING_SCALE_RST[READ_TIME_BIT];
    end else begin
      flash_wr_go_o      <= flash_op & (key_r == KEY_OPEN);
      xram_wr_go_o       <= xmove_wr_i & ~program_write_enable_i;
      flash_locked_o     <= (key_nxt != KEY_OPEN);
      read_time_select_o <= rtime_r;
    end
  end

  flash_read_strobe u_strobe (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .read_req_i   (flash_read_i),
    .oneshot_en_i (oneshot_r),
    .sense_en_o   (sense_en_o)
  );
endmodule

// ==== flash_key_ctrl_monitor.sv ====
`timescale 1ns/100ps
module flash_key_ctrl_monitor
  import flash_key_pkg::*;
(
  input logic clk_i,
  input logic rst_n_i,
  input logic [7:0] sfr_addr_i,
  input logic [7:0] sfr_wdata_i,
  input logic sfr_wr_i,
  input logic program_write_enable_i,
  input logic xmove_wr_i,
  input logic flash_wr_go_o,
  input logic flash_locked_o,
  input logic read_time_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence op_s; xmove_wr_i && program_write_enable_i; endsequence
  a_go_open: assert property (!flash_locked_o ##0 op_s |=> flash_wr_go_o) else $error("go lost");
  a_go_shut: assert property (flash_locked_o ##0 op_s |=> !flash_wr_go_o) else $error("locked go");
  a_go_relock: assert property (flash_wr_go_o |-> flash_locked_o) else $error("no relock");
  a_go_route: assert property (xmove_wr_i && !program_write_enable_i |=> !flash_wr_go_o) else $error("xram");
  a_key_open: assert property ($fell(flash_locked_o) |-> $past(sfr_wdata_i) == KEY_SECOND) else $error("key");
  // The select bit passes the scale register and then the output flop, so it shows two edges on
  a_time_copy: assert property (sfr_wr_i && sfr_addr_i == FLASH_TIMING_SCALE_ADDR |-> ##2
    read_time_select_o == $past(sfr_wdata_i[READ_TIME_BIT], 2)) else $error("read time");
endmodule
bind flash_key_ctrl flash_key_ctrl_monitor flash_key_ctrl_monitor_inst (.*);

// ==== tb_flash_key_ctrl.sv ====
`timescale 1ns/100ps
`define CHK(n,e,s) begin check_count++; if ((s)!==(e)) begin mismatches++; \
  $display("unexpected %s %h %h",n,e,s); end end
module tb_flash_key_ctrl;
  logic clk_i = 0, rst_n_i = 0, sfr_wr_i = 0, sfr_rd_i = 0, xmove_wr_i = 0, flash_read_i = 0;
  logic program_write_enable_i = 0, flash_wr_go_o, xram_wr_go_o, flash_locked_o, read_time_select_o, sense_en_o;
  logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, sfr_rdata_o;
  logic [31:0] seed = 32'h42A7;
  int mismatches = 0, check_count = 0;
  always #25 clk_i = ~clk_i;
  flash_key_ctrl flash_key_ctrl_inst (.*);
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], ^(s & 32'h80200003)};
  endfunction
  task automatic op(logic [2:0] c, logic [7:0] a, d);
    @(negedge clk_i);
    {sfr_wr_i, sfr_rd_i, xmove_wr_i, sfr_addr_i, sfr_wdata_i} = {c, a, d};
    @(negedge clk_i);
    {sfr_wr_i, sfr_rd_i, xmove_wr_i} = 3'h0;
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #40000 mismatches++;
    close_out;
  end
  initial begin
    #100 rst_n_i = 1;
    op(2, 8'hB6, 0);
    `CHK("scale", 8'h80, sfr_rdata_o)
    op(2, 8'hB7, 0);
    `CHK("lock", 8'h00, sfr_rdata_o)
    // Read held high so the one-shot pulse has ended by each check
    flash_read_i = 1;
    repeat (4) begin
      seed = lfsr(seed);
      op(4, 8'hB6, seed[7:0]);
      op(2, 8'hB6, 0);
      `CHK("scale", seed[7:0] & 8'h90, sfr_rdata_o)
      `CHK("sense", !seed[7], sense_en_o)
    end
    op(4, 8'hB7, 8'hA5);
    op(2, 8'hB7, 0);
    `CHK("lock", 8'h01, sfr_rdata_o)
    op(4, 8'hB7, 8'hF1);
    op(2, 8'hB7, 0);
    `CHK("lock", 8'h02, sfr_rdata_o)
    `CHK("locked", 1'b0, flash_locked_o)
    for (int i = 0; i < 3; i++) begin
      program_write_enable_i = i != 1;
      op(1, 0, 0);
      `CHK("go", {i == 0, i == 1}, {flash_wr_go_o, xram_wr_go_o})
    end
    op(2, 8'hB7, 0);
    `CHK("lock", 8'h03, sfr_rdata_o)
    `CHK("locked", 1'b1, flash_locked_o)
    // Only a reset may clear the dead state
    @(negedge clk_i);
    rst_n_i = 0;
    @(negedge clk_i);
    rst_n_i = 1;
    op(2, 8'hB7, 0);
    `CHK("lock", 8'h00, sfr_rdata_o)
    op(2, 8'hB6, 0);
    `CHK("scale", 8'h80, sfr_rdata_o)
    close_out;
  end
endmodule
